// ==== rtl/pmc_power_ctrl.sv ====
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
module pmc_power_ctrl #(
   parameter int POR_CYCLES = pmc_pkg::PMC_POR_CYCLES,
   parameter int LOCK_CYCLES = pmc_pkg::PMC_LOCK_CYCLES,
   parameter int OSC_CYCLES = pmc_pkg::PMC_OSC_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins from outside, asynchronous
   input wire logic ext_reset_n,
   input wire logic supply_above_por,
   // interrupt requests from the core, same clock
   input wire logic any_enabled_irq,
   input wire logic interval_timer_irq,
   input wire logic interval_timer_enable,
   input wire logic serial_irq,
   input wire logic ext_int_zero_irq,
   // clock and power controls
   output logic core_clk_en,
   output logic periph_clk_en,
   output logic interval_timer_clk_en,
   output logic pll_en,
   output logic osc_en,
   output logic pll_locked,
   // pin state controls
   output logic pins_hold,
   output logic conv_out_hiz,
   output logic strobe_override,
   output logic addr_latch_strobe,
   output logic program_fetch_strobe,
   // chip reset, status and interrupt
   output logic chip_reset_n,
   output logic [1:0] power_mode,
   output logic irq
);
   import pmc_pkg::*;

   // counters must fit the shared counter width
   if (POR_CYCLES < 1 || POR_CYCLES >= (1 << PMC_CNT_W)) begin : g_chk_por
      $error("POR_CYCLES out of range");
   end
   if (LOCK_CYCLES < 1 || LOCK_CYCLES >= (1 << PMC_CNT_W)) begin : g_chk_lock
      $error("LOCK_CYCLES out of range");
   end
   if (OSC_CYCLES < 1 || OSC_CYCLES >= (1 << PMC_CNT_W)) begin : g_chk_osc
      $error("OSC_CYCLES out of range");
   end

   // every flip-flop of the block
   typedef struct packed {
      logic rst_s1; // reset pin, first stage
      logic rst_s2; // reset pin, second stage
      logic sup_s1; // supply comparator, first stage
      logic sup_s2; // supply comparator, second stage
      pmc_por_e por; // power-on reset sequence
      logic [PMC_CNT_W-1:0] por_cnt; // por hold timer
      pmc_mode_e mode; // current power mode
      pmc_lock_e lock; // pll relock sequence
      logic [PMC_CNT_W-1:0] lock_cnt; // relock / start-up timer
      logic idle_req; // power control bit 0
      logic pdown_req; // power control bit 1
      logic ser_wake; // serial_wake_enable_bit
      logic ext0_wake; // ext_int_zero_wake_enable_bit
      logic oscillator_powerdown_bit; // oscillator_powerdown_bit
      logic [PMC_NUM_EV-1:0] irq_stat; // sticky events
      logic [PMC_NUM_EV-1:0] irq_mask; // event enables
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic core_clk_en;
      logic periph_clk_en;
      logic itimer_clk_en;
      logic pll_en;
      logic osc_en;
      logic pins_hold;
      logic conv_hiz;
      logic strobe_ovr;
      logic ale;
      logic pfs;
      logic chip_rst_n;
      logic irq;
      logic locked; // pll lock flag, drives pll_locked
   } pmc_state_s;

   pmc_state_s s; // registered state
   pmc_state_s next_s; // next state

   // decoded helpers, filled by the combinational process
   logic acc; // apb access phase
   logic wr_fire; // write takes effect this edge
   logic [PMC_NUM_EV-1:0] ev; // events raised this cycle
   logic [PMC_NUM_EV-1:0] w1c; // status bits cleared by software
   logic pd_wake; // legal power-down wake source
   logic chip_in_reset; // por or pin reset active
   pmc_mode_e m; // mode after this cycle's decisions

   // read data for one offset; unmapped reads give zero
   function automatic logic [31:0] rd_mux(input pmc_state_s st, input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         PMC_PWR_CTRL_OFF: begin
            r[PMC_IDLE_BIT] = st.idle_req;
            r[PMC_PDOWN_BIT] = st.pdown_req;
            r[PMC_SER_WAKE_BIT] = st.ser_wake;
            r[PMC_EXT0_WAKE_BIT] = st.ext0_wake;
         end
         PMC_PLL_CTRL_OFF: begin
            r[PMC_OSCILLATOR_POWERDOWN_BIT_BIT] = st.oscillator_powerdown_bit;
            r[PMC_LOCK_BIT] = (st.lock == PMC_LK_LOCKED);
         end
         PMC_IRQ_STAT_OFF: r[PMC_NUM_EV-1:0] = st.irq_stat;
         PMC_IRQ_MASK_OFF: r[PMC_NUM_EV-1:0] = st.irq_mask;
         PMC_STATUS_OFF: r[1:0] = st.mode;
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   // true for the five implemented offsets
   function automatic logic is_mapped(input logic [7:0] a);
      return (a == PMC_PWR_CTRL_OFF) || (a == PMC_PLL_CTRL_OFF) ||
             (a == PMC_IRQ_STAT_OFF) || (a == PMC_IRQ_MASK_OFF) ||
             (a == PMC_STATUS_OFF);
   endfunction

   // all next-state logic
   always_comb begin
      next_s = s;
      ev = '0;
      w1c = '0;
      // pins pass two flip-flops before anything reads them
      next_s.rst_s1 = ext_reset_n;
      next_s.rst_s2 = s.rst_s1;
      next_s.sup_s1 = supply_above_por;
      next_s.sup_s2 = s.sup_s1;

      if (!s.sup_s2) begin
         next_s.por = PMC_POR_HOLD;
         next_s.por_cnt = '0;
      end else begin
         case (s.por)
            PMC_POR_HOLD: begin
               // supply just crossed the threshold: start the timer
               next_s.por = PMC_POR_TIMING;
               next_s.por_cnt = PMC_CNT_W'(POR_CYCLES - 1);
            end
            PMC_POR_TIMING: begin
               if (s.por_cnt == '0) begin
                  next_s.por = PMC_POR_DONE;
               end else begin
                  next_s.por_cnt = s.por_cnt - 1'b1;
               end
            end
            PMC_POR_DONE: next_s.por = PMC_POR_DONE;
            default: next_s.por = PMC_POR_HOLD;
         endcase
      end
      chip_in_reset = (s.por != PMC_POR_DONE) || !s.rst_s2;

      // apb: pready comes one cycle into the access phase
      acc = psel && penable;
      wr_fire = acc && s.pready && pwrite;
      next_s.pready = acc && !s.pready;
      next_s.pslverr = acc && !s.pready && !is_mapped(paddr);
      if (acc && !s.pready && !pwrite) begin
         next_s.prdata = rd_mux(s, paddr);
      end

      pd_wake = 1'b0;
      if (!s.oscillator_powerdown_bit && interval_timer_enable && interval_timer_irq) begin
         pd_wake = 1'b1;
      end
      if (s.ser_wake && serial_irq) begin
         pd_wake = 1'b1;
      end
      if (s.ext0_wake && ext_int_zero_irq) begin
         pd_wake = 1'b1;
      end

      // mode sequencing; a wake clears the request bit it served
      m = s.mode;
      case (s.mode)
         PMC_NORMAL: begin
            if (s.pdown_req) begin
               m = PMC_PDOWN;
            end else if (s.idle_req) begin
               m = PMC_IDLE;
            end
         end
         PMC_IDLE: begin
            if (any_enabled_irq) begin
               m = PMC_NORMAL;
               next_s.idle_req = 1'b0;
               ev[PMC_EV_IDLE_WAKE] = 1'b1;
            end
         end
         PMC_PDOWN: begin
            if (pd_wake) begin
               m = PMC_NORMAL;
               next_s.pdown_req = 1'b0;
               next_s.idle_req = 1'b0;
               ev[PMC_EV_PD_WAKE] = 1'b1;
            end
         end
         default: m = PMC_NORMAL;
      endcase
      next_s.mode = m;

      // relock timer starts on leaving power-down
      case (s.lock)
         PMC_LK_LOCKED: begin
            // pll stops in power-down, so lock is lost there
            if (m == PMC_PDOWN) begin
               next_s.lock = PMC_LK_PLL;
               next_s.lock_cnt = PMC_CNT_W'(LOCK_CYCLES - 1);
            end
         end
         PMC_LK_OSC: begin
            if (m != PMC_PDOWN) begin
               if (s.lock_cnt == '0) begin
                  next_s.lock = PMC_LK_PLL;
                  next_s.lock_cnt = PMC_CNT_W'(LOCK_CYCLES - 1);
               end else begin
                  next_s.lock_cnt = s.lock_cnt - 1'b1;
               end
            end
         end
         PMC_LK_PLL: begin
            if (m == PMC_PDOWN) begin
               // re-arm while asleep; a stopped crystal needs start-up
               next_s.lock = s.oscillator_powerdown_bit ? PMC_LK_OSC : PMC_LK_PLL;
               next_s.lock_cnt = s.oscillator_powerdown_bit ? PMC_CNT_W'(OSC_CYCLES - 1) :
                                            PMC_CNT_W'(LOCK_CYCLES - 1);
            end else if (s.lock_cnt == '0) begin
               next_s.lock = PMC_LK_LOCKED;
               ev[PMC_EV_LOCK] = 1'b1;
            end else begin
               next_s.lock_cnt = s.lock_cnt - 1'b1;
            end
         end
         default: next_s.lock = PMC_LK_LOCKED;
      endcase

      // register writes, taken at the edge where pready is seen high
      if (wr_fire) begin
         case (paddr)
            PMC_PWR_CTRL_OFF: begin
               next_s.idle_req = pwdata[PMC_IDLE_BIT];
               next_s.pdown_req = pwdata[PMC_PDOWN_BIT];
               next_s.ser_wake = pwdata[PMC_SER_WAKE_BIT];
               next_s.ext0_wake = pwdata[PMC_EXT0_WAKE_BIT];
            end
            PMC_PLL_CTRL_OFF: next_s.oscillator_powerdown_bit = pwdata[PMC_OSCILLATOR_POWERDOWN_BIT_BIT];
            PMC_IRQ_STAT_OFF: w1c = pwdata[PMC_NUM_EV-1:0];
            PMC_IRQ_MASK_OFF: next_s.irq_mask = pwdata[PMC_NUM_EV-1:0];
            default: w1c = '0;
         endcase
      end
      // a new event beats a clear written in the same cycle
      next_s.irq_stat = (s.irq_stat & ~w1c) | ev;

      // reset pin ends power-down and restores defaults
      if (chip_in_reset) begin
         // leaving power-down by reset still has to relock the pll
         if (s.mode == PMC_PDOWN && s.lock == PMC_LK_LOCKED) begin
            next_s.lock = PMC_LK_PLL;
            next_s.lock_cnt = PMC_CNT_W'(LOCK_CYCLES - 1);
         end
         next_s.mode = PMC_NORMAL;
         {next_s.ext0_wake, next_s.ser_wake, next_s.pdown_req, next_s.idle_req} =
            PMC_PWR_CTRL_RST;
         next_s.oscillator_powerdown_bit = PMC_OSCILLATOR_POWERDOWN_BIT_RST;
         next_s.irq_stat = PMC_IRQ_RST;
         next_s.irq_mask = PMC_IRQ_RST;
      end

      // outputs registered from the next mode so they track it exactly
      // idle gates only the core clock
      next_s.core_clk_en = (next_s.mode == PMC_NORMAL);
      // peripherals lose their clock only in power-down
      next_s.periph_clk_en = (next_s.mode != PMC_PDOWN);
      next_s.itimer_clk_en = !((next_s.mode == PMC_PDOWN) && next_s.oscillator_powerdown_bit);
      // pll off in power-down, crystal per its bit
      next_s.pll_en = (next_s.mode != PMC_PDOWN);
      next_s.osc_en = !((next_s.mode == PMC_PDOWN) && next_s.oscillator_powerdown_bit);
      // power-down keeps pins, converter hiz, strobes low
      next_s.pins_hold = (next_s.mode != PMC_NORMAL);
      next_s.conv_hiz = (next_s.mode == PMC_PDOWN);
      next_s.strobe_ovr = (next_s.mode != PMC_NORMAL);
      next_s.ale = (next_s.mode == PMC_IDLE);
      next_s.pfs = (next_s.mode == PMC_IDLE);
      // core reset: por or pin, released to the reset vector
      next_s.chip_rst_n = !chip_in_reset;
      next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
      // lock flag kept in a flop so the pin never glitches on a state change
      next_s.locked = (next_s.lock == PMC_LK_LOCKED);
   end

   // one register bank; async reset loads constants only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.por <= PMC_POR_HOLD;
         s.mode <= PMC_NORMAL;
         s.lock <= PMC_LK_LOCKED;
         s.locked <= 1'b1;
         s.core_clk_en <= 1'b1;
         s.periph_clk_en <= 1'b1;
         s.itimer_clk_en <= 1'b1;
         s.pll_en <= 1'b1;
         s.osc_en <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // every output straight from its flip-flop
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign core_clk_en = s.core_clk_en;
   assign periph_clk_en = s.periph_clk_en;
   assign interval_timer_clk_en = s.itimer_clk_en;
   assign pll_en = s.pll_en;
   assign osc_en = s.osc_en;
   assign pll_locked = s.locked;
   assign pins_hold = s.pins_hold;
   assign conv_out_hiz = s.conv_hiz;
   assign strobe_override = s.strobe_ovr;
   assign addr_latch_strobe = s.ale;
   assign program_fetch_strobe = s.pfs;
   assign chip_reset_n = s.chip_rst_n;
   assign power_mode = s.mode;
   assign irq = s.irq;
endmodule

// ==== rtl/pmc_pkg.sv ====
package pmc_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] PMC_PWR_CTRL_OFF = 8'h00;
   localparam logic [7:0] PMC_PLL_CTRL_OFF = 8'h04;
   localparam logic [7:0] PMC_IRQ_STAT_OFF = 8'h08;
   localparam logic [7:0] PMC_IRQ_MASK_OFF = 8'h0C;
   localparam logic [7:0] PMC_STATUS_OFF = 8'h10;
   // power_control_register field positions
   localparam int PMC_IDLE_BIT = 0;
   localparam int PMC_PDOWN_BIT = 1;
   localparam int PMC_SER_WAKE_BIT = 2;
   localparam int PMC_EXT0_WAKE_BIT = 3;
   // pll_control_register field positions
   localparam int PMC_OSCILLATOR_POWERDOWN_BIT_BIT = 3;
   localparam int PMC_LOCK_BIT = 6;
   // interrupt status / mask field positions
   localparam int PMC_EV_IDLE_WAKE = 0;
   localparam int PMC_EV_PD_WAKE = 1;
   localparam int PMC_EV_LOCK = 2;
   localparam int PMC_NUM_EV = 3;
   // values after reset
   localparam logic [3:0] PMC_PWR_CTRL_RST = 4'h0;
   localparam logic PMC_OSCILLATOR_POWERDOWN_BIT_RST = 1'b0;
   localparam logic [2:0] PMC_IRQ_RST = 3'h0;
   // timing: figures in ms, counts derived from the 100 MHz clock
   localparam int PMC_CLK_KHZ = 100000;
   localparam int PMC_POR_TIME_MS = 128;
   localparam int PMC_LOCK_TIME_MS = 1;
   localparam int PMC_OSC_START_MS = 150;
   localparam int PMC_POR_CYCLES = PMC_POR_TIME_MS * PMC_CLK_KHZ;
   localparam int PMC_LOCK_CYCLES = PMC_LOCK_TIME_MS * PMC_CLK_KHZ;
   localparam int PMC_OSC_CYCLES = PMC_OSC_START_MS * PMC_CLK_KHZ;
   localparam int PMC_CNT_W = 24;
   // operating modes
   typedef enum logic [1:0] {
      PMC_NORMAL,
      PMC_IDLE,
      PMC_PDOWN
   } pmc_mode_e;
   // internal power-on reset sequence
   typedef enum logic [1:0] {
      PMC_POR_HOLD,
      PMC_POR_TIMING,
      PMC_POR_DONE
   } pmc_por_e;
   // pll relock sequence after a wake
   typedef enum logic [1:0] {
      PMC_LK_LOCKED,
      PMC_LK_OSC,
      PMC_LK_PLL
   } pmc_lock_e;
endpackage

// ==== test/pmc_power_ctrl_checker.sv ====
`timescale 1ns/1ps
module pmc_power_ctrl_checker #(
   parameter int LOCK_CYCLES = 10,
   parameter int OSC_CYCLES = 30
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // pins and requests
   input wire logic ext_reset_n,
   input wire logic supply_above_por,
   input wire logic any_enabled_irq,
   input wire logic interval_timer_irq,
   input wire logic interval_timer_enable,
   input wire logic serial_irq,
   input wire logic ext_int_zero_irq,
   // controls from the block
   input wire logic core_clk_en,
   input wire logic periph_clk_en,
   input wire logic interval_timer_clk_en,
   input wire logic pll_en,
   input wire logic osc_en,
   input wire logic pll_locked,
   input wire logic pins_hold,
   input wire logic strobe_override,
   input wire logic conv_out_hiz,
   input wire logic addr_latch_strobe,
   input wire logic program_fetch_strobe,
   input wire logic chip_reset_n,
   input wire logic [1:0] power_mode
);
   import pmc_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // cycles since power-down was left
   int since_wake;
   // oscillator was stopped in the last power-down, so relock is longer
   logic osc_off;
   // a relock is expected
   logic woke;
   // relock time that the last wake calls for
   int lock_need;
   assign lock_need = osc_off ? LOCK_CYCLES + OSC_CYCLES : LOCK_CYCLES;
   // track the last wake; cleared once lock returns
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         since_wake <= 0;
         osc_off <= 1'b0;
         woke <= 1'b0;
      end else if (power_mode == PMC_PDOWN) begin
         since_wake <= 0;
         woke <= 1'b1;
         osc_off <= osc_off | !osc_en;
      end else begin
         since_wake <= since_wake + 1;
         if (pll_locked) begin
            woke <= 1'b0;
            osc_off <= 1'b0;
         end
      end
   end
   pd_entry_a: assert property (
      psel && penable && pready && pwrite && paddr == PMC_PWR_CTRL_OFF && pwdata[PMC_PDOWN_BIT]
      |-> ##[1:3] power_mode == PMC_PDOWN) else $error("power-down not entered");
   idle_clk_a: assert property (
      power_mode == PMC_IDLE |-> !core_clk_en && periph_clk_en && pll_en && osc_en)
      else $error("idle clocks wrong");
   idle_pins_a: assert property (
      power_mode == PMC_IDLE |-> pins_hold && addr_latch_strobe && program_fetch_strobe
      && !conv_out_hiz && strobe_override) else $error("idle pins wrong");
   idle_wake_a: assert property (
      power_mode == PMC_IDLE && any_enabled_irq |=> power_mode == PMC_NORMAL)
      else $error("idle not left");
   pd_clk_a: assert property (
      power_mode == PMC_PDOWN |-> !pll_en && !core_clk_en && !periph_clk_en
      && interval_timer_clk_en == osc_en) else $error("power-down clocks wrong");
   pd_pins_a: assert property (
      power_mode == PMC_PDOWN |-> pins_hold && conv_out_hiz && !addr_latch_strobe
      && !program_fetch_strobe && strobe_override) else $error("power-down pins wrong");
   normal_out_a: assert property (
      power_mode == PMC_NORMAL |-> core_clk_en && periph_clk_en && pll_en && osc_en
      && interval_timer_clk_en && !pins_hold && !conv_out_hiz && !strobe_override)
      else $error("normal outputs wrong");
   ext_reset_a: assert property (
      (!ext_reset_n) [*5] |-> !chip_reset_n && power_mode == PMC_NORMAL)
      else $error("external reset ignored");
   timer_wake_a: assert property (
      power_mode == PMC_PDOWN && interval_timer_irq && interval_timer_enable && osc_en
      |=> power_mode == PMC_NORMAL) else $error("timer wake missed");
   por_hold_a: assert property (
      (!supply_above_por) [*5] |-> !chip_reset_n) else $error("reset released at low supply");
   relock_a: assert property (
      $rose(pll_locked) && woke |-> since_wake + 2 >= lock_need && since_wake <= lock_need + 4)
      else $error("relock time wrong");
   pd_hold_a: assert property (
      power_mode == PMC_PDOWN && !interval_timer_irq && !serial_irq && !ext_int_zero_irq
      && ext_reset_n && $past(ext_reset_n) && $past(ext_reset_n, 2) && $past(ext_reset_n, 3)
      && supply_above_por && $past(supply_above_por) && $past(supply_above_por, 2)
      && $past(supply_above_por, 3)
      |=> power_mode == PMC_PDOWN) else $error("power-down left without cause");
   // main scenarios reached
   cover property (power_mode == PMC_IDLE);
   cover property (power_mode == PMC_PDOWN && !osc_en);
   cover property ($rose(pll_locked) && woke);
endmodule
bind pmc_power_ctrl pmc_power_ctrl_checker #(.LOCK_CYCLES(LOCK_CYCLES),
   .OSC_CYCLES(OSC_CYCLES)) u_chk (.*);

// ==== test/pmc_core_model.sv ====
`timescale 1ns/1ps
module pmc_core_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench requests: 0 enabled irq, 1 timer, 2 serial, 3 ext int 0
   input wire logic [3:0] raise,
   // core clock gate from the controller
   input wire logic core_clk_en,
   // interrupt levels towards the controller
   output logic any_enabled_irq,
   output logic interval_timer_irq,
   output logic serial_irq,
   output logic ext_int_zero_irq
);
   // requests waiting for a running core
   logic [3:0] pend;
   // held until served
   // a source keeps asking until the core runs, as a real flag would
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend <= 4'h0;
      end else if (core_clk_en) begin
         pend <= 4'h0;
      end else begin
         pend <= pend | raise;
      end
   end
   assign any_enabled_irq = pend[0];
   assign interval_timer_irq = pend[1];
   assign serial_irq = pend[2];
   assign ext_int_zero_irq = pend[3];
endmodule

// ==== test/power_mode_and_por_control_tb_top.sv ====
`timescale 1ns/1ps
module power_mode_and_por_control_tb_top;
   import pmc_pkg::*;
   // short counts keep the run brief
   localparam int POR = 20;
   localparam int LOCK = 10;
   localparam int OSC = 30;
   // one row: control write, wake source, mode it should give
   typedef struct {
      logic [3:0] ctrl;
      logic [3:0] src;
      logic [1:0] mode;
   } pmc_row_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, idle;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic ext_reset_n, supply_above_por, interval_timer_enable, chip_reset_n, irq;
   logic any_enabled_irq, interval_timer_irq, serial_irq, ext_int_zero_irq;
   logic core_clk_en, periph_clk_en, interval_timer_clk_en, pll_en, osc_en, pll_locked;
   logic pins_hold, conv_out_hiz, strobe_override, addr_latch_strobe, program_fetch_strobe;
   logic [1:0] power_mode;
   logic [3:0] raise;
   int num_errors = 0;
   int comparisons = 0;
   int n;
   pmc_row_s rows [5] = '{'{4'h1, 4'h1, PMC_IDLE}, '{4'h2, 4'h2, PMC_PDOWN},
      '{4'h6, 4'h4, PMC_PDOWN}, '{4'hA, 4'h8, PMC_PDOWN}, '{4'h3, 4'h2, PMC_PDOWN}};
   // design and far side; the checker is bound inside the design
   pmc_power_ctrl #(.POR_CYCLES(POR), .LOCK_CYCLES(LOCK), .OSC_CYCLES(OSC)) dut (.*);
   pmc_core_model u_core (.*);
   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   function automatic logic [31:0] bit32(input int b);
      return 32'h0000_0001 << b;
   endfunction
   task automatic tick(input int k);
      repeat (k) @(posedge pclk);
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one transfer; held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      // let an edge pass so a release just made is not overwritten in one step
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 50) begin
         num_errors++;
         $display("[FAIL] pready expected 1 seen timeout");
         close_out();
      end
   endtask
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(what, exp, rd);
   endtask
   // the core only sees a request once the mode change has landed
   task automatic fire(input logic [3:0] src);
      tick(2);
      raise <= src;
      tick(1);
      raise <= 4'h0;
   endtask
   // 0 waits for mode m, 1 for lock, 2 for the chip out of reset
   task automatic wait_for(input int what, input logic [1:0] m);
      n = 0;
      while (n < 400 && !(what == 0 ? power_mode === m :
            what == 1 ? pll_locked === 1'b1 : chip_reset_n === 1'b1)) begin
         @(posedge pclk);
         n++;
      end
      if (n == 400) begin
         num_errors++;
         $display("[FAIL] wait %0d expected done seen timeout", what);
         close_out();
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, raise} = '0;
      {presetn, supply_above_por} = 2'b00;
      {ext_reset_n, interval_timer_enable} = 2'b11;
      tick(10);
      presetn <= 1'b1;
      tick(6);
      check("por hold", 0, chip_reset_n);
      supply_above_por <= 1'b1;
      wait_for(2, 2'd0);
      check("por time", 1, n >= POR + 3 && n <= POR + 8);
      rdc("ctrl reset", PMC_PWR_CTRL_OFF, 32'(PMC_PWR_CTRL_RST));
      rdc("pll reset", PMC_PLL_CTRL_OFF, bit32(PMC_LOCK_BIT));
      rdc("stat reset", PMC_IRQ_STAT_OFF, 32'h0000_0000);
      apb(1'b1, 8'h20, 32'hFFFF_FFFF);
      check("slverr", 1, err);
      rdc("unmapped", 8'h20, 32'h0000_0000);
      apb(1'b1, PMC_IRQ_MASK_OFF, 32'h0000_0003);
      // ordinary entries and wakes, one row each
      foreach (rows[i]) begin
         idle = rows[i].mode == PMC_IDLE;
         apb(1'b1, PMC_PWR_CTRL_OFF, 32'(rows[i].ctrl));
         tick(2);
         check("mode", rows[i].mode, power_mode);
         check("clocks", {1'b0, idle, idle}, {core_clk_en, periph_clk_en, pll_en});
         check("strobes", {idle, idle}, {addr_latch_strobe, program_fetch_strobe});
         check("pins", {1'b1, !idle, 1'b1}, {pins_hold, conv_out_hiz, strobe_override});
         rdc("mode reg", PMC_STATUS_OFF, 32'(rows[i].mode));
         fire(rows[i].src);
         wait_for(0, PMC_NORMAL);
         wait_for(1, 2'd0);
         check("normal", 3'b110, {core_clk_en, pll_en, strobe_override});
         check("irq", 1, irq);
         rdc("status", PMC_IRQ_STAT_OFF, idle ? bit32(PMC_EV_IDLE_WAKE) :
            bit32(PMC_EV_PD_WAKE) | bit32(PMC_EV_LOCK));
         apb(1'b1, PMC_IRQ_STAT_OFF, 32'h0000_0007);
         tick(2);
         check("irq clear", 0, irq);
      end
      // unarmed sources and a disabled timer leave power-down alone
      interval_timer_enable <= 1'b0;
      apb(1'b1, PMC_PWR_CTRL_OFF, 32'h0000_0002);
      fire(4'hF);
      tick(20);
      check("no wake", PMC_PDOWN, power_mode);
      interval_timer_enable <= 1'b1;
      wait_for(0, PMC_NORMAL);
      wait_for(1, 2'd0);
      // stopped oscillator: no timer wake, longer relock
      apb(1'b1, PMC_PLL_CTRL_OFF, bit32(PMC_OSCILLATOR_POWERDOWN_BIT_BIT));
      apb(1'b1, PMC_PWR_CTRL_OFF, 32'h0000_000A);
      fire(4'h2);
      tick(10);
      check("osc off", 3'b001, {osc_en, interval_timer_clk_en, power_mode == PMC_PDOWN});
      fire(4'h8);
      wait_for(0, PMC_NORMAL);
      wait_for(1, 2'd0);
      check("relock", 1, n >= OSC + LOCK - 4 && n <= OSC + LOCK + 4);
      rdc("pll", PMC_PLL_CTRL_OFF, bit32(PMC_OSCILLATOR_POWERDOWN_BIT_BIT) | bit32(PMC_LOCK_BIT));
      apb(1'b1, PMC_PLL_CTRL_OFF, 32'h0000_0000);
      // power cycle in power-down: por hold, then a fresh timed release
      apb(1'b1, PMC_PWR_CTRL_OFF, 32'h0000_0002);
      tick(2);
      supply_above_por <= 1'b0;
      tick(6);
      check("power cycle", 3'b000, {power_mode, chip_reset_n});
      supply_above_por <= 1'b1;
      wait_for(2, 2'd0);
      check("por again", 1, n >= POR + 3 && n <= POR + 8);
      rdc("ctrl after cycle", PMC_PWR_CTRL_OFF, 32'(PMC_PWR_CTRL_RST));
      // external reset in power-down
      apb(1'b1, PMC_PWR_CTRL_OFF, 32'h0000_0006);
      tick(2);
      ext_reset_n <= 1'b0;
      tick(6);
      check("pin reset", 3'b000, {power_mode, chip_reset_n});
      ext_reset_n <= 1'b1;
      wait_for(2, 2'd0);
      rdc("ctrl default", PMC_PWR_CTRL_OFF, 32'(PMC_PWR_CTRL_RST));
      rdc("mask default", PMC_IRQ_MASK_OFF, 32'(PMC_IRQ_RST));
      wait_for(1, 2'd0);
      apb(1'b1, PMC_IRQ_STAT_OFF, 32'h0000_0007);
      // masked idle wake, then unmask and clear
      apb(1'b1, PMC_PWR_CTRL_OFF, 32'h0000_0001);
      fire(4'h1);
      wait_for(0, PMC_NORMAL);
      tick(2);
      check("irq masked", 0, irq);
      rdc("idle wake", PMC_IRQ_STAT_OFF, bit32(PMC_EV_IDLE_WAKE));
      apb(1'b1, PMC_IRQ_MASK_OFF, 32'h0000_0001);
      tick(2);
      check("irq unmasked", 1, irq);
      apb(1'b1, PMC_IRQ_STAT_OFF, 32'h0000_0001);
      tick(2);
      check("irq w1c", 0, irq);
      close_out();
   end
endmodule
